// File: bench/tb.sv
// testbench for the receive endpoint block
// register port driven here, link side by the host model
`timescale 1ns/1ns
module tb;
  import usb_rx_pkg::*;
  logic ref_clk, rstn, regWrEn, regRdEn, frameLsb, linkReady;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData, st;
  token_t tokIn;
  rxBeat_t beatIn;
  handshake_t hsOut, hsSeen;
  logic [2:0] warnEv, warnSeen;
  int errors, tests_run;
  typedef struct {logic [7:0] cmd; tokKind_t k; logic [1:0] ep; logic [7:0] pid;
    int n; logic [2:0] hs; logic [7:0] st;} row_t;
  row_t rows[5] = '{'{8'h21, TOK_OUT, 2'h0, 8'h4B, 4, 3'h4, 8'h34},
    '{8'h01, TOK_OUT, 2'h1, 8'hC3, 2, 3'h4, 8'h12},
    '{8'h00, TOK_OUT, 2'h2, 8'h4B, 1, 3'h5, 8'h00},
    '{8'h04, TOK_SETUP, 2'h2, 8'hC3, 2, 3'h0, 8'h00},
    '{8'h00, TOK_SETUP, 2'h2, 8'hC3, 2, 3'h4, 8'h52}};
  usb_rx_endpoint_ctrl usb_rx_endpoint_ctrl_i (.ref_clk, .rstn, .regAddr, .regWrEn,
    .regRdEn, .regWrData, .regRdData, .tokIn, .beatIn, .frameNumberLowBit(frameLsb),
    .linkReady, .hsOut, .receiveWarningEvent(warnEv));
  usb_host_model usb_host_model_i (.ref_clk, .linkReady, .tokIn, .beatIn);
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (hsOut.valid)
      hsSeen <= hsOut;
    // cleared in reset: the event output is unknown before the first edge
    warnSeen <= rstn ? (warnSeen | warnEv) : 3'h0;
  end
  function automatic logic [5:0] ba(input logic [1:0] e);
    return 6'h2C + {1'b0, e, 3'h0};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic [5:0] a, input logic [7:0] d, input logic w);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = w;
    regRdEn = !w;
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    st = regRdData;
  endtask
  task automatic pkt(input tokKind_t k, input logic [1:0] ep, input logic [7:0] pid,
    input int n, input logic e, input logic [2:0] hs);
    hsSeen = '0;
    usb_host_model_i.send(k, ep, pid, n, e);
    repeat (3) @(posedge ref_clk);
    chk("handshake", {5'h0, hs}, {5'h0, hsSeen});
  endtask
  task automatic end_sim;
    $display("comparisons %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {rstn, regWrEn, regRdEn, frameLsb, regAddr, regWrData} = '0;
    hsSeen = '0;
    warnSeen = '0;
    errors = 0;
    tests_run = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    foreach (rows[i])
    begin
      acc(ba(rows[i].ep) + 6'h3, rows[i].cmd, 1'b1);
      pkt(rows[i].k, rows[i].ep, rows[i].pid, rows[i].n, 1'b0, rows[i].hs);
      acc(ba(rows[i].ep) + 6'h2, 8'h00, 1'b0);
      chk("status", rows[i].st, st);
    end
    pkt(TOK_SETUP, 2'h2, 8'hC3, 3, 1'b0, 3'h4);
    acc(6'h3E, 8'h00, 1'b0);
    chk("count", 8'h02, st & 8'h0F);
    acc(6'h3F, 8'h08, 1'b1);
    acc(6'h3E, 8'h00, 1'b0);
    chk("flush", 8'h00, st);
    chk("warning", 8'h01, {5'h0, warnSeen});
    for (int i = 0; i < 4; i++)
    begin
      acc(6'h2D, 8'h00, 1'b0);
      chk("data", 8'hA0 + 8'(i), st);
    end
    acc(6'h2E, 8'h00, 1'b0);
    chk("drained", 8'h00, st);
    acc(6'h2F, 8'h00, 1'b0);
    chk("command", 8'h20, st);
    pkt(TOK_OUT, 2'h0, 8'h4B, 1, 1'b0, 3'h5);
    acc(6'h3C, 8'h80, 1'b1);
    acc(6'h3F, 8'h01, 1'b1);
    pkt(TOK_OUT, 2'h2, 8'h4B, 1, 1'b0, 3'h6);
    acc(6'h3F, 8'h00, 1'b0);
    chk("stall arm", 8'h00, st);
    acc(6'h37, 8'h01, 1'b1);
    pkt(TOK_OUT, 2'h1, 8'h4B, 2, 1'b1, 3'h0);
    acc(6'h36, 8'h00, 1'b0);
    chk("error", 8'h80, st & 8'h80);
    acc(6'h37, 8'h08, 1'b1);
    acc(6'h36, 8'h00, 1'b0);
    chk("flush", 8'h00, st);
    acc(6'h37, 8'h01, 1'b1);
    pkt(TOK_OUT, 2'h1, 8'h4B, 0, 1'b0, 3'h4);
    pkt(TOK_SETUP, 2'h1, 8'hC3, 2, 1'b0, 3'h4);
    acc(6'h36, 8'h00, 1'b0);
    chk("first copy", 8'h00, st & 8'h40);
    acc(6'h36, 8'h00, 1'b0);
    chk("second copy", 8'h40, st & 8'h40);
    frameLsb = 1'b1;
    acc(6'h2C, 8'h20, 1'b1);
    acc(6'h2F, 8'h01, 1'b1);
    pkt(TOK_OUT, 2'h0, 8'hC3, 1, 1'b0, 3'h4);
    acc(6'h2E, 8'h00, 1'b0);
    chk("iso status", 8'h31, st);
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("ready in reset", 8'h00, {7'h0, linkReady});
    rstn = 1'b1;
    @(posedge ref_clk);
    #1;
    chk("ready after reset", 8'h01, {7'h0, linkReady});
    for (int e = 0; e < 3; e++)
    begin
      acc(ba(2'(e)) + 6'h2, 8'h00, 1'b0);
      chk("reset status", 8'h00, st);
      acc(ba(2'(e)) + 6'h3, 8'h00, 1'b0);
      chk("reset command", 8'h00, st);
    end
    acc(6'h00, 8'h00, 1'b0);
    chk("unmapped", 8'h00, st);
    end_sim();
  end
endmodule

// File: bench/usb_host_model.sv
// host model: token, PID, payload, two CRC bytes, end marker
// assumes the block paces bytes with linkReady; drives just after edges
`timescale 1ns/1ns
module usb_host_model
  import usb_rx_pkg::*;
(
  input wire logic ref_clk, // device clock
  input wire logic linkReady, // block may take a byte
  output token_t tokIn, // token pulse
  output rxBeat_t beatIn // byte and end beats
);
  initial
  begin
    tokIn = '0;
    beatIn = '0;
  end
  task automatic beat(input token_t t, input rxBeat_t b);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    while (!linkReady && b.byteValid)
    begin
      n++;
      if (n > 100)
      begin
        tb.errors++;
        tb.end_sim();
      end
      @(posedge ref_clk);
      #1;
    end
    tokIn = t;
    beatIn = b;
    @(posedge ref_clk);
    #1;
    tokIn = '0;
    // released data lines show the inverse so a stale byte never looks valid
    beatIn = '{1'b0, ~b.data, 1'b0, 1'b0};
  endtask
  task automatic send(input tokKind_t k, input logic [1:0] ep, input logic [7:0] pid,
    input int n, input logic err);
    beat('{1'b1, k, ep}, '0);
    beat('0, '{1'b1, pid, 1'b0, 1'b0});
    for (int i = 0; i < n + 2; i++)
      beat('0, '{1'b1, 8'hA0 + 8'(i), 1'b0, 1'b0}); // last two are the CRC16
    beat('0, '{1'b0, 8'h00, 1'b1, err});
  endtask
endmodule

// File: bench/usb_rx_assertions.sv
// port checker for the receive endpoint block
// bound into every usb_rx_endpoint_ctrl; sees its ports only
`timescale 1ns/1ns
module usb_rx_chk
  import usb_rx_pkg::*;
(
  input wire logic ref_clk, // device clock
  input wire logic rstn, // reset, active low
  input wire logic [5:0] regAddr, // register address
  input wire logic regRdEn, // read strobe
  input wire logic [7:0] regRdData, // read data
  input wire token_t tokIn, // token
  input wire rxBeat_t beatIn, // link beats
  input wire handshake_t hsOut, // handshake
  input wire logic [2:0] receiveWarningEvent // warning pulses
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // a packet end between the two reads could legally reload the bits
  sequence rdStat;
    regRdEn && regAddr[2:0] == 3'h6 && regAddr >= 6'h2C && !tokIn.valid && !beatIn.endValid;
  endsequence
  sequence gap;
    !regRdEn && !tokIn.valid && !beatIn.endValid;
  endsequence
  a_hs_one_cycle: assert property (hsOut.valid |=> !hsOut.valid)
    else $error("handshake longer than one cycle");
  a_hs_has_cause: assert property (hsOut.valid |-> $past(beatIn.endValid) || $past(tokIn.valid))
    else $error("handshake without cause");
  a_err_no_hs: assert property (beatIn.endValid && beatIn.mediaErr |=> !hsOut.valid)
    else $error("handshake after media error");
  a_stall_after_out: assert property (hsOut.valid && hsOut.code == HS_STALL |->
    $past(tokIn.valid) && $past(tokIn.kind) == TOK_OUT)
    else $error("stall not after out token");
  a_rd_holds: assert property (!$past(regRdEn) |-> $stable(regRdData))
    else $error("read data changed without read");
  a_warn_one_ep: assert property ($onehot0(receiveWarningEvent))
    else $error("warnings on two endpoints");
  a_stat_clears: assert property (rdStat ##1 gap ##1 (rdStat and regAddr == $past(regAddr, 2))
    |=> !regRdData[5])
    else $error("toggle survived status read");
  a_unmapped_zero: assert property (regRdEn && regAddr < 6'h2C |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_quiet_reset: assert property (!$past(rstn) |-> !hsOut.valid && receiveWarningEvent == 3'h0)
    else $error("output active after reset");
endmodule

bind usb_rx_endpoint_ctrl usb_rx_chk chk_i (.ref_clk, .rstn, .regAddr, .regRdEn,
  .regRdData, .tokIn, .beatIn, .hsOut, .receiveWarningEvent);

// File: hw/usb_rx_defs.svh
// constants for the receive endpoint control block: map, fields, sizes
// assumes an 8-bit register port with a 6-bit address space
`ifndef USB_RX_DEFS_SVH
`define USB_RX_DEFS_SVH
`define RX_NUM_EP 3
`define RX_FIFO_W 8
`define RX_FIFO_DEPTH 8
`define RX_FIFO_CW 4
`define RX_ADDR_W 6
`define RX_BASE0 6'h2C
`define ST_ERR 7
`define ST_SETUP 6
`define ST_TOGGLE 5
`define ST_LAST 4
`define CMD_EN 0
`define CMD_IGN 2
`define CMD_FLUSH 3
`define CMD_WL_LO 5
`define CMD_WL_HI 6
`define EPC_ISO 5
`define EPC_STALL 7
`define WARN_L1 5'h04
`define WARN_L2 5'h08
`define WARN_L3 5'h10
`define PID_DATA1 8'h4B
`define CNT_MAX 4'hF
`endif

// File: hw/usb_rx_endpoint_ctrl.sv
// receive endpoint control: status, command and data registers of three
// receive endpoints, packet reception from the serial engine, 8-word fifos
// assumes the serial engine delivers token, PID, payload, CRC16 in order and
// honours linkReady; register port is 8-bit, one access per cycle
`timescale 1ns/1ns
`include "usb_rx_defs.svh"

module rx_byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk, // device clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic flush, // drop contents, reset pointers
  input wire logic inValid, // write strobe
  output logic inReady, // space available
  input wire logic [W-1:0] inData, // write byte
  output logic outValid, // data available
  input wire logic outReady, // pop strobe
  output logic [W-1:0] outData, // head of fifo
  output logic [$clog2(DEPTH+1)-1:0] count // words held
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } fifoState_t;
  fifoState_t s_q, s_d;
  logic doPush, doPop;

  assign inReady = s_q.cnt != CW'(DEPTH);
  assign outValid = s_q.cnt != '0;
  assign outData = s_q.mem[s_q.rp];
  assign count = s_q.cnt;

  always_comb
  begin
    s_d = s_q;
    doPush = inValid && inReady;
    doPop = outReady && outValid;
    if (doPush)
    begin
      s_d.mem[s_q.wp] = inData;
      s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (doPop)
      s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + CW'(doPush) - CW'(doPop);
    if (flush)
    begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule

module usb_rx_endpoint_ctrl
  import usb_rx_pkg::*;
(
  input wire logic ref_clk, // device clock, 50 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic [`RX_ADDR_W-1:0] regAddr, // register address
  input wire logic regWrEn, // write strobe, one cycle
  input wire logic regRdEn, // read strobe, one cycle
  input wire logic [7:0] regWrData, // write data
  output logic [7:0] regRdData, // read data, valid cycle after strobe
  input wire token_t tokIn, // token from the serial engine
  input wire rxBeat_t beatIn, // PID/payload/CRC bytes and packet end
  input wire logic frameNumberLowBit, // frame_number_low bit 0
  output logic linkReady, // engine may send a byte this cycle
  output handshake_t hsOut, // handshake to send, one-cycle pulse
  output logic [`RX_NUM_EP-1:0] receiveWarningEvent // pulse per endpoint
);
  localparam int N = `RX_NUM_EP;
  localparam int CW = `RX_FIFO_CW;

  typedef struct packed {
    epState_t [N-1:0] ep;
    rxState_t rx;
    logic [7:0] rdData;
    logic ready;
    handshake_t hs;
    logic [N-1:0] warnEvt;
  } top_t;
  top_t s_q, s_d;

  logic [N-1:0] push, pop, flush, fifoValid, fifoInReady;
  logic [7:0] pushData;
  logic [N-1:0][7:0] fifoOut;
  logic [N-1:0][CW-1:0] fifoCount;

  function automatic regSel_t decodeAddr(input logic [`RX_ADDR_W-1:0] a);
    regSel_t r;
    logic [`RX_ADDR_W-1:0] off;
    off = a - `RX_BASE0;
    r.hit = (a >= `RX_BASE0) && !off[5] && !off[2] && (off[4:3] != 2'h3);
    r.ep = off[4:3];
    r.kind = regKind_t'(off[1:0]);
    return r;
  endfunction

  function automatic logic [4:0] warnLimit(input logic [1:0] lvl);
    logic [4:0] l;
    unique case (lvl)
      2'h1: l = `WARN_L1;
      2'h2: l = `WARN_L2;
      2'h3: l = `WARN_L3;
      2'h0: l = 5'h00;
    endcase
    return l;
  endfunction

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gFifo
      rx_byte_fifo #(.W(`RX_FIFO_W), .DEPTH(`RX_FIFO_DEPTH)) uFifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .flush(flush[g]),
        .inValid(push[g]),
        .inReady(fifoInReady[g]),
        .inData(pushData),
        .outValid(fifoValid[g]),
        .outReady(pop[g]),
        .outData(fifoOut[g]),
        .count(fifoCount[g])
      );
    end
  endgenerate

  always_comb
  begin
    regSel_t sel;
    epState_t e;
    logic [6:0] nBytes;
    logic [CW-1:0] cnt;
    logic [CW:0] nc;
    logic [4:0] lim;
    logic tog;
    s_d = s_q;
    sel = decodeAddr(regAddr);
    e = s_q.ep[0];
    nBytes = '0;
    cnt = '0;
    nc = '0;
    lim = '0;
    tog = 1'b0;
    s_d.hs.valid = 1'b0;
    s_d.warnEvt = '0;
    push = '0;
    pop = '0;
    flush = '0;
    pushData = s_q.rx.dly[0];

    // register writes
    if (regWrEn && sel.hit)
    begin
      unique case (sel.kind)
        REG_CTL: s_d.ep[sel.ep].epc = regWrData;
        REG_CMD:
        begin
          s_d.ep[sel.ep].rxEn = regWrData[`CMD_EN];
          s_d.ep[sel.ep].ignSetup = regWrData[`CMD_IGN];
          s_d.ep[sel.ep].warnLvl = regWrData[`CMD_WL_HI:`CMD_WL_LO];
          s_d.ep[sel.ep].warnCnt = '0; // count only bytes after the level is set
          if (regWrData[`CMD_FLUSH])
            s_d.ep[sel.ep].flushPend = 1'b1;
        end
        REG_DATA, REG_STAT: ;
      endcase
    end

    // register reads; clear-on-read first so hardware sets below win
    if (regRdEn && sel.hit)
    begin
      e = s_q.ep[sel.ep];
      cnt = fifoCount[sel.ep];
      unique case (sel.kind)
        REG_CTL: s_d.rdData = e.epc;
        REG_DATA:
        begin
          s_d.rdData = fifoOut[sel.ep];
          pop[sel.ep] = fifoValid[sel.ep];
        end
        REG_STAT:
        begin
          s_d.rdData = {e.stat, (cnt > 4'(`CNT_MAX)) ? `CNT_MAX : cnt};
          if (e.stat2Valid)
          begin
            s_d.ep[sel.ep].stat = e.stat2;
            s_d.ep[sel.ep].stat2Valid = 1'b0;
          end
          else
            s_d.ep[sel.ep].stat = '0;
          s_d.ep[sel.ep].zlpHeld = 1'b0;
        end
        REG_CMD:
          s_d.rdData = {1'b0, e.warnLvl, 1'b0, e.flushPend, e.ignSetup, 1'b0, e.rxEn};
      endcase
    end
    else if (regRdEn)
      s_d.rdData = 8'h00;

    // token handling; tokens during a packet are ignored
    if (tokIn.valid && s_q.rx.phase == RX_IDLE && tokIn.ep != 2'h3)
    begin
      e = s_q.ep[tokIn.ep];
      s_d.rx.ep = tokIn.ep;
      s_d.rx.isSetup = tokIn.kind == TOK_SETUP;
      s_d.rx.gotPid = 1'b0;
      s_d.rx.held = '0;
      s_d.rx.bytes = '0;
      s_d.rx.accept = 1'b0;
      s_d.rx.endHs = '0;
      unique case (tokIn.kind)
        TOK_SETUP:
        begin
          if (!e.ignSetup)
          begin
            s_d.rx.phase = RX_BUSY;
            if (e.setupHeld)
              s_d.rx.endHs = '{valid: 1'b1, code: HS_ACK};
            else if (e.flushPend)
              s_d.rx.endHs = '0;
            else
              s_d.rx.accept = 1'b1;
          end
        end
        TOK_OUT:
        begin
          s_d.ep[tokIn.ep].setupHeld = 1'b0;
          if (e.epc[`EPC_STALL])
          begin
            s_d.hs = '{valid: 1'b1, code: HS_STALL};
            s_d.ep[tokIn.ep].rxEn = 1'b0;
          end
          else
          begin
            s_d.rx.phase = RX_BUSY;
            s_d.rx.accept = e.rxEn && !e.flushPend;
            s_d.rx.endHs = '{valid: 1'b1, code: HS_NAK};
          end
        end
        TOK_OTHER: s_d.ep[tokIn.ep].setupHeld = 1'b0;
      endcase
    end

    // data bytes: first is the PID, last two (CRC16) never reach the fifo
    if (beatIn.byteValid && s_q.rx.phase == RX_BUSY)
    begin
      if (!s_q.rx.gotPid)
      begin
        s_d.rx.gotPid = 1'b1;
        s_d.rx.pidData1 = beatIn.data == `PID_DATA1;
      end
      else if (s_q.rx.accept)
      begin
        if (s_q.rx.held == 2'h2)
        begin
          push[s_q.rx.ep] = fifoInReady[s_q.rx.ep];
          s_d.rx.bytes = s_q.rx.bytes + 7'h01;
          s_d.rx.dly[0] = s_q.rx.dly[1];
          s_d.rx.dly[1] = beatIn.data;
        end
        else
        begin
          s_d.rx.dly[s_q.rx.held[0]] = beatIn.data;
          s_d.rx.held = s_q.rx.held + 2'h1;
        end
      end
    end

    // packet end
    if (beatIn.endValid && s_q.rx.phase == RX_BUSY)
    begin
      s_d.rx.phase = RX_IDLE;
      e = s_q.ep[s_q.rx.ep];
      nBytes = s_d.rx.bytes;
      if (beatIn.mediaErr)
      begin
        if (s_q.rx.accept)
          s_d.ep[s_q.rx.ep].stat.err = 1'b1;
      end
      else if (s_q.rx.accept)
      begin
        if (e.epc[`EPC_ISO])
          tog = frameNumberLowBit;
        else if (nBytes != '0)
          tog = s_q.rx.pidData1;
        else
          tog = s_d.ep[s_q.rx.ep].stat.toggle;
        if (s_q.rx.isSetup && nBytes != '0 && e.zlpHeld)
        begin
          s_d.ep[s_q.rx.ep].stat2 = '{err: 1'b0, setup: 1'b1, toggle: tog, last: 1'b1};
          s_d.ep[s_q.rx.ep].stat2Valid = 1'b1;
        end
        else
        begin
          s_d.ep[s_q.rx.ep].stat.toggle = tog;
          if (s_q.rx.isSetup)
            s_d.ep[s_q.rx.ep].stat.setup = 1'b1;
          if (nBytes != '0)
            s_d.ep[s_q.rx.ep].stat.last = 1'b1;
          else
            s_d.ep[s_q.rx.ep].zlpHeld = 1'b1;
        end
        s_d.ep[s_q.rx.ep].setupHeld = s_q.rx.isSetup;
        s_d.ep[s_q.rx.ep].rxEn = 1'b0;
        s_d.hs = '{valid: 1'b1, code: HS_ACK};
      end
      else if (s_q.rx.endHs.valid)
        s_d.hs = s_q.rx.endHs;
    end

    // deferred flush and warning counting per endpoint
    for (int i = 0; i < N; i++)
    begin
      if (s_q.ep[i].flushPend && !(s_q.rx.phase == RX_BUSY && s_q.rx.ep == 2'(i)))
      begin
        flush[i] = 1'b1;
        s_d.ep[i].flushPend = 1'b0;
        s_d.ep[i].warnCnt = '0;
        s_d.ep[i].setupHeld = 1'b0;
        s_d.ep[i].zlpHeld = 1'b0;
      end
      lim = warnLimit(s_q.ep[i].warnLvl);
      if (push[i] && lim != '0 && s_q.ep[i].warnCnt < lim)
      begin
        s_d.ep[i].warnCnt = s_q.ep[i].warnCnt + 5'h01;
        if (s_q.ep[i].warnCnt + 5'h01 == lim)
          s_d.warnEvt[i] = 1'b1;
      end
    end

    // registered ready: space in the fifo the engine is writing next cycle
    nc = {1'b0, fifoCount[s_d.rx.ep]} + (CW+1)'(push[s_d.rx.ep])
      - (CW+1)'(pop[s_d.rx.ep]);
    if (flush[s_d.rx.ep])
      nc = '0;
    s_d.ready = !(s_d.rx.phase == RX_BUSY && s_d.rx.accept)
      || nc < (CW+1)'(`RX_FIFO_DEPTH);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign regRdData = s_q.rdData;
  assign linkReady = s_q.ready;
  assign hsOut = s_q.hs;
  assign receiveWarningEvent = s_q.warnEvt;
endmodule

// File: hw/usb_rx_pkg.sv
// types shared by the receive endpoint control block
// assumes usb_rx_defs.svh is on the include path
package usb_rx_pkg;
  `include "usb_rx_defs.svh"
  typedef enum logic [1:0] {TOK_OUT, TOK_SETUP, TOK_OTHER} tokKind_t;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL} hsCode_t;
  typedef enum logic [1:0] {REG_CTL, REG_DATA, REG_STAT, REG_CMD} regKind_t;
  typedef enum logic {RX_IDLE, RX_BUSY} rxPhase_t;
  typedef struct packed {logic valid; tokKind_t kind; logic [1:0] ep;} token_t;
  typedef struct packed {logic byteValid; logic [7:0] data; logic endValid; logic mediaErr;} rxBeat_t;
  typedef struct packed {logic valid; hsCode_t code;} handshake_t;
  typedef struct packed {logic err; logic setup; logic toggle; logic last;} rxStat_t;
  typedef struct packed {logic hit; logic [1:0] ep; regKind_t kind;} regSel_t;
  typedef struct packed {
    logic [7:0] epc;
    logic rxEn;
    logic ignSetup;
    logic [1:0] warnLvl;
    logic flushPend;
    rxStat_t stat;
    rxStat_t stat2;
    logic stat2Valid;
    logic zlpHeld;
    logic setupHeld;
    logic [4:0] warnCnt;
  } epState_t;
  typedef struct packed {
    rxPhase_t phase;
    logic [1:0] ep;
    logic isSetup;
    logic accept;
    handshake_t endHs;
    logic gotPid;
    logic pidData1;
    logic [1:0] held;
    logic [1:0][7:0] dly;
    logic [6:0] bytes;
  } rxState_t;
endpackage
